// ===== common/reset_init_pkg.sv
package reset_init_pkg;

    // ------------------------------------------------------------
    // clock and time units
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // phase timing, in osc_input_clock cycles unless named _MS; NZ_BYTES_MIN and NZ_BYTES_MAX are byte counts
    // ------------------------------------------------------------
    localparam int unsigned STATE_NOBOOT_CYC = 1300;
    localparam int unsigned STATE_BOOT_CYC = 70000;
    localparam int unsigned STATE_BYTE_MS = 25;
    localparam int unsigned STATE_BYTE_CYC = STATE_BYTE_MS * CYC_PER_MS;
    localparam int unsigned NZ_BYTES_MIN = 10;
    localparam int unsigned NZ_BYTES_MAX = 504;
    localparam int unsigned XRAM_BASE_CYC = 24000;
    localparam int unsigned XRAM_TEST_PER_BYTE = 214;
    localparam int unsigned XRAM_CLR_PER_BYTE = 152;
    localparam int unsigned SYSRAM_BASE_CYC = 27000;
    localparam int unsigned SYSRAM_PER_BUF = 1500;
    localparam int unsigned CKSUM_NOBOOT_CYC = 7200;
    localparam int unsigned CKSUM_BOOT_CYC = 82000;
    localparam int unsigned CKSUM_BOOT_MS = 100;
    localparam int unsigned CKSUM_BOOT_EXTRA = CKSUM_BOOT_MS * CYC_PER_MS;
    localparam int unsigned CKSUM_PER_BYTE = 175;

    // ------------------------------------------------------------
    // maintenance pin timing
    // ------------------------------------------------------------
    localparam int unsigned PIN_HALF_CYC = 65536;
    localparam int unsigned LED_BLINK_MS = 1000;
    localparam int unsigned LED_HALF_CYC = LED_BLINK_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // widths and device state codes
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 32;
    localparam int unsigned UID_W = 48;
    localparam int unsigned PROG_ID_W = 64;
    localparam logic [3:0] CODE_APPLESS = 4'h3;
    localparam logic [3:0] CODE_UNCONFIG = 4'h2;
    localparam logic [3:0] CODE_OFFLINE = 4'h6;
    localparam logic [3:0] CODE_CONFIG = 4'h4;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_STATE = 3'b001,
        PH_XRAM = 3'b010,
        PH_SYSRAM = 3'b011,
        PH_CKSUM = 3'b100,
        PH_DONE = 3'b101
    } phase_t;

endpackage

// ===== verilog/reset_init_and_maint_pin_control.sv
`timescale 1ns/1ns

// Summary of operation
// - state init takes 1300 cycles, or 70000 plus 25 ms per non-zero byte on boot
// - non-zero boot byte count is held between 10 and 504
// - ram init 24000 plus 214 per byte testing, 152 per app byte clearing
// - with ram test disabled, only the application ram area is cleared
// - system ram setup takes 27000 plus 1500 per allocated buffer
// - checksum init 7200 plus 175 per byte, or 82000 plus 100 ms on boot
// - boot checksum timing only when booting into configured or unconfigured state
// - port init and seed calculation overlap other phases, adding no time
// - pin alternates input and open-drain output, 50% duty, 76 Hz at 10 MHz
// - alternation rate scales with the input clock, 50 Hz at 6.5536 MHz
// - on-chip pull-up holds the pin high as input, enabled by default
// - led blinks at 1/2 Hz while no network address is configured
// - led on for code 3, flashing for code 2, off for codes 6 and 4
// - grounding the active-low pin requests an identification message
// - at most one identification message per pin transition
// - message goes into the next free priority or non-priority buffer
// - applicationless device without external pull-up sends message after each reset
// - pin level is ignored while reset is applied
module reset_init_and_maint_pin_control
    import reset_init_pkg::*;
#(
    parameter int unsigned STATE_BOOT = STATE_BOOT_CYC,
    parameter int unsigned STATE_BYTE = STATE_BYTE_CYC,
    parameter int unsigned XRAM_BASE = XRAM_BASE_CYC,
    parameter int unsigned SYSRAM_BASE = SYSRAM_BASE_CYC,
    parameter int unsigned CKSUM_NOBOOT = CKSUM_NOBOOT_CYC,
    parameter int unsigned CKSUM_BOOT = CKSUM_BOOT_CYC,
    parameter int unsigned CKSUM_EXTRA = CKSUM_BOOT_EXTRA,
    parameter int unsigned PIN_HALF = PIN_HALF_CYC,
    parameter int unsigned LED_HALF = LED_HALF_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic boot_req_i,
    input wire logic boot_to_appless_i,
    input wire logic [8:0] nz_bytes_i,
    input wire logic ram_present_i,
    input wire logic ram_test_en_i,
    input wire logic [15:0] ram_bytes_i,
    input wire logic [15:0] app_ram_bytes_i,
    input wire logic [7:0] buffers_i,
    input wire logic [15:0] cksum_bytes_i,
    input wire logic [3:0] state_code_i,
    input wire logic pullup_dis_i,
    input wire logic maint_pin_i,
    input wire logic prio_buf_free_i,
    input wire logic nonprio_buf_free_i,
    input wire logic [UID_W-1:0] node_unique_id_i,
    input wire logic [PROG_ID_W-1:0] prog_id_i,
    output logic maint_pin_o,
    output logic maint_oe_o,
    output logic maint_pullup_o,
    output logic [2:0] phase_o,
    output logic init_done_o,
    output logic par_init_run_o,
    output logic id_push_o,
    output logic id_prio_o,
    output logic [UID_W-1:0] id_uid_o,
    output logic [PROG_ID_W-1:0] id_prog_o
);

    // ------------------------------------------------------------
    // phase lengths
    // ------------------------------------------------------------
    phase_t phase;
    phase_t next_phase;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_len;
    wire logic [8:0] nz_lo = (nz_bytes_i < 9'(NZ_BYTES_MIN)) ? 9'(NZ_BYTES_MIN) : nz_bytes_i;
    wire logic [8:0] nz_cl = (nz_lo > 9'(NZ_BYTES_MAX)) ? 9'(NZ_BYTES_MAX) : nz_lo;
    wire logic [CNT_W-1:0] len_state = boot_req_i
        ? CNT_W'(STATE_BOOT + 64'(nz_cl) * STATE_BYTE)
        : CNT_W'(STATE_NOBOOT_CYC);
    // clearing only touches the application area, so its size drives the count
    wire logic [CNT_W-1:0] len_xram = ram_test_en_i
        ? CNT_W'(XRAM_BASE + 32'(ram_bytes_i) * XRAM_TEST_PER_BYTE)
        : CNT_W'(XRAM_BASE + 32'(app_ram_bytes_i) * XRAM_CLR_PER_BYTE);
    wire logic [CNT_W-1:0] len_sysram =
        CNT_W'(SYSRAM_BASE + 32'(buffers_i) * SYSRAM_PER_BUF);
    wire logic cksum_long = boot_req_i && !boot_to_appless_i;
    wire logic [CNT_W-1:0] len_cksum = cksum_long
        ? CNT_W'(CKSUM_BOOT + CKSUM_EXTRA + 32'(cksum_bytes_i) * CKSUM_PER_BYTE)
        : CNT_W'(CKSUM_NOBOOT + 32'(cksum_bytes_i) * CKSUM_PER_BYTE);
    wire logic phase_end = (cnt == '0);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // port init and seed calculation run beside the timed phases, so
    // they get no phase of their own and only a busy level
    always_comb begin
        next_phase = phase;
        next_len = '0;
        case (phase)
            PH_IDLE: begin
                next_phase = PH_STATE;
                next_len = len_state;
            end
            PH_STATE: begin
                if (phase_end) begin
                    // no off-chip ram means nothing to test or clear
                    if (ram_present_i) begin
                        next_phase = PH_XRAM;
                        next_len = len_xram;
                    end else begin
                        next_phase = PH_SYSRAM;
                        next_len = len_sysram;
                    end
                end
            end
            PH_XRAM: begin
                if (phase_end) begin
                    next_phase = PH_SYSRAM;
                    next_len = len_sysram;
                end
            end
            PH_SYSRAM: begin
                if (phase_end) begin
                    next_phase = PH_CKSUM;
                    next_len = len_cksum;
                end
            end
            PH_CKSUM: begin
                if (phase_end) begin
                    next_phase = PH_DONE;
                end
            end
            PH_DONE: begin
                next_phase = PH_DONE;
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
    end

    // a phase of length n holds for n cycles: load n-1, leave at zero
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            phase <= PH_IDLE;
            cnt <= '0;
        end else if (ce_i) begin
            phase <= next_phase;
            if (next_phase != phase) begin
                cnt <= (next_len == '0) ? '0 : next_len - 1'b1;
            end else if (!phase_end) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            phase_o <= PH_IDLE;
            init_done_o <= 1'b0;
            par_init_run_o <= 1'b0;
        end else if (ce_i) begin
            phase_o <= next_phase;
            init_done_o <= (next_phase == PH_DONE);
            par_init_run_o <= (next_phase != PH_IDLE) && (next_phase != PH_DONE);
        end
    end

    // ------------------------------------------------------------
    // pin alternation and led pattern
    // ------------------------------------------------------------
    logic [16:0] alt_cnt;
    logic [CNT_W-1:0] led_cnt;
    logic led_flash;
    // the top bit of a 2^17 divider gives two equal halves of 2^16
    wire logic alt_drive = alt_cnt[16];
    wire logic alt_last = (alt_cnt[15:0] == 16'(PIN_HALF - 1));
    wire logic code_on = (state_code_i == CODE_APPLESS);
    wire logic code_flash = (state_code_i == CODE_UNCONFIG);
    // any other code, offline and configured among them, keeps the led dark
    wire logic led_lit = code_on || (code_flash && led_flash);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            alt_cnt <= '0;
        end else if (ce_i) begin
            if (alt_last) begin
                alt_cnt <= {~alt_cnt[16], 16'h0000};
            end else begin
                alt_cnt <= alt_cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            led_cnt <= '0;
            led_flash <= 1'b0;
        end else if (ce_i) begin
            if (led_cnt == CNT_W'(LED_HALF - 1)) begin
                led_cnt <= '0;
                led_flash <= ~led_flash;
            end else begin
                led_cnt <= led_cnt + 1'b1;
            end
        end
    end

    // open drain: the data bit is always low, only the enable moves
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            maint_pin_o <= 1'b0;
            maint_oe_o <= 1'b0;
            maint_pullup_o <= 1'b0;
        end else if (ce_i) begin
            maint_pin_o <= 1'b0;
            maint_oe_o <= alt_drive && led_lit && init_done_o;
            maint_pullup_o <= !pullup_dis_i && !alt_drive;
        end
    end

    // ------------------------------------------------------------
    // pin sampling and identification message
    // ------------------------------------------------------------
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic id_pend;
    // reset forces both stages high so a floating pin during reset reads idle
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else if (ce_i) begin
            pin_s1 <= maint_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    // sample at the end of the three-state half so the pin has settled
    // and our own low drive cannot be mistaken for a button press
    wire logic sample_now = init_done_o && !alt_drive && alt_last;
    // previous level starts high: a pin held low with no pull-up fires once
    wire logic press = sample_now && !pin_s2 && pin_prev;
    wire logic buf_free = prio_buf_free_i || nonprio_buf_free_i;
    wire logic push = id_pend && buf_free;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_prev <= 1'b1;
            id_pend <= 1'b0;
        end else if (ce_i) begin
            if (sample_now) begin
                pin_prev <= pin_s2;
            end
            // a new press in the push cycle keeps the request pending
            if (press) begin
                id_pend <= 1'b1;
            end else if (push) begin
                id_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            id_push_o <= 1'b0;
            id_prio_o <= 1'b0;
            id_uid_o <= '0;
            id_prog_o <= '0;
        end else if (ce_i) begin
            id_push_o <= push;
            if (push) begin
                id_prio_o <= prio_buf_free_i;
                id_uid_o <= node_unique_id_i;
                id_prog_o <= prog_id_i;
            end
        end
    end

endmodule

// ===== tb/reset_init_props.sv
`timescale 1ns/1ns
module reset_init_props
    import reset_init_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic boot_req_i,
    input wire logic pullup_dis_i,
    input wire logic prio_buf_free_i,
    input wire logic nonprio_buf_free_i,
    input wire logic [UID_W-1:0] node_unique_id_i,
    input wire logic maint_pin_o,
    input wire logic maint_oe_o,
    input wire logic maint_pullup_o,
    input wire logic [2:0] phase_o,
    input wire logic init_done_o,
    input wire logic par_init_run_o,
    input wire logic id_push_o,
    input wire logic id_prio_o,
    input wire logic [UID_W-1:0] id_uid_o
);
    // ----------------------------------------
    // state phase length counter
    // ----------------------------------------
    logic [15:0] run;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || phase_o != 3'h1) begin
            run <= 16'h0;
        end else begin
            run <= run + 16'h1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    chk_pin_data_low: assert property (maint_pin_o == 1'h0)
        else $error("pin data not low");
    chk_drive_no_pull: assert property (maint_oe_o |-> !maint_pullup_o)
        else $error("pull-up on while driving");
    chk_pull_disabled: assert property (maint_pullup_o |-> !$past(pullup_dis_i))
        else $error("pull-up on while disabled");
    chk_done_holds: assert property (init_done_o |=> init_done_o && phase_o == 3'h5)
        else $error("done dropped");
    chk_run_flag: assert property (par_init_run_o == (phase_o inside {[3'h1:3'h4]}))
        else $error("run flag wrong");
    chk_state_len: assert property ($fell(phase_o == 3'h1) && !boot_req_i |-> run == 16'd1300)
        else $error("state phase length wrong");
    chk_push_single: assert property (id_push_o |=> !id_push_o)
        else $error("push longer than one cycle");
    chk_push_buffer: assert property (id_push_o |-> id_prio_o == $past(prio_buf_free_i)
        && ($past(prio_buf_free_i) || $past(nonprio_buf_free_i)))
        else $error("push buffer choice wrong");
    chk_push_uid: assert property (id_push_o |-> id_uid_o == $past(node_unique_id_i))
        else $error("message id wrong");
    chk_led_after_done: assert property (maint_oe_o |-> init_done_o)
        else $error("pin driven before done");
endmodule

// ===== tb/maint_button_model.sv
`timescale 1ns/1ns
module maint_button_model (
    input wire logic clk_sys_i,
    input wire logic maint_oe_i,
    input wire logic maint_pullup_i,
    input wire logic press_i,
    input wire logic ext_pullup_i,
    output logic pad_o
);
    logic wander = 1'h0;
    // an unpulled, undriven pad must never read as a steady level
    always @(posedge clk_sys_i) begin
        wander <= ~wander;
    end
    assign pad_o = (maint_oe_i || press_i) ? 1'h0
        : (maint_pullup_i || ext_pullup_i) ? 1'h1 : wander;
endmodule

// ===== tb/test_reset_init_and_maint_pin_control.sv
`timescale 1ns/1ns
module test_reset_init_and_maint_pin_control;
    import reset_init_pkg::*;
    localparam int unsigned SB = 20, SE = 3, XB = 20, YB = 20, CN = 30, CB = 25, CX = 7;
    localparam int unsigned PH = 16, LH = 40;
    logic clk_sys_i = 1'h0, rstn_i = 1'h0, ce_i = 1'h1, press = 1'h0, ext_pu = 1'h0;
    logic boot_req_i = 1'h0, boot_to_appless_i = 1'h0, ram_present_i = 1'h1;
    logic ram_test_en_i = 1'h1, pullup_dis_i = 1'h0, prio_buf_free_i = 1'h1;
    logic nonprio_buf_free_i = 1'h1;
    logic [8:0] nz_bytes_i = 9'h0;
    logic [15:0] ram_bytes_i = 16'h0, app_ram_bytes_i = 16'h0, cksum_bytes_i = 16'h0;
    logic [7:0] buffers_i = 8'h0;
    logic [3:0] state_code_i = 4'h3;
    logic [UID_W-1:0] node_unique_id_i = '0, id_uid_o;
    logic [PROG_ID_W-1:0] prog_id_i = '0, id_prog_o;
    logic maint_pin_i, maint_pin_o, maint_oe_o, maint_pullup_o, init_done_o;
    logic par_init_run_o, id_push_o, id_prio_o;
    logic [2:0] phase_o;
    int unsigned err_total = 0, checks = 0, pushes = 0;

    reset_init_and_maint_pin_control #(.STATE_BOOT(SB), .STATE_BYTE(SE), .XRAM_BASE(XB),
        .SYSRAM_BASE(YB), .CKSUM_NOBOOT(CN), .CKSUM_BOOT(CB), .CKSUM_EXTRA(CX),
        .PIN_HALF(PH), .LED_HALF(LH)) u_reset_init_and_maint_pin_control (.clk_sys_i,
        .rstn_i, .ce_i, .boot_req_i, .boot_to_appless_i, .nz_bytes_i, .ram_present_i,
        .ram_test_en_i, .ram_bytes_i, .app_ram_bytes_i, .buffers_i, .cksum_bytes_i,
        .state_code_i, .pullup_dis_i, .maint_pin_i, .prio_buf_free_i, .nonprio_buf_free_i,
        .node_unique_id_i, .prog_id_i, .maint_pin_o, .maint_oe_o, .maint_pullup_o, .phase_o,
        .init_done_o, .par_init_run_o, .id_push_o, .id_prio_o, .id_uid_o, .id_prog_o);
    maint_button_model u_maint_button_model (.clk_sys_i, .maint_oe_i(maint_oe_o),
        .maint_pullup_i(maint_pullup_o), .press_i(press), .ext_pullup_i(ext_pu),
        .pad_o(maint_pin_i));

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (id_push_o === 1'h1) pushes <= pushes + 1;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    function automatic int unsigned exp_len(input logic [2:0] p);
        int unsigned e;
        e = (nz_bytes_i < 10) ? 10 : (nz_bytes_i > 504) ? 504 : nz_bytes_i;
        case (p)
            3'h1: return boot_req_i ? SB + e * SE : 1300;
            3'h2: return XB + (ram_test_en_i ? 214 * ram_bytes_i : 152 * app_ram_bytes_i);
            3'h3: return YB + 1500 * buffers_i;
            default: return (boot_req_i && !boot_to_appless_i ? CB + CX : CN)
                + 175 * cksum_bytes_i;
        endcase
    endfunction
    task automatic run_init();
        int unsigned n = 1;
        logic [2:0] cur = 3'h1;
        rstn_i = 1'h0;
        tick(3);
        rstn_i = 1'h1;
        pushes = 0;
        tick(1);
        check("phase_o", 64'h1, phase_o);
        for (int k = 0; k < 40000 && cur !== 3'h5; k++) begin
            tick(1);
            if (phase_o === cur) begin
                n++;
            end else begin
                check("phase length", exp_len(cur), n);
                check("phase_o", (cur == 3'h1 && !ram_present_i) ? 3'h3 : cur + 3'h1, phase_o);
                cur = phase_o;
                n = 1;
            end
        end
        check("done and run", 64'h2, {init_done_o, par_init_run_o});
        if (cur !== 3'h5) begin
            err_total++;
            end_of_test();
        end
    endtask
    task automatic span(input logic lvl);
        int unsigned n = 0;
        for (int k = 0; k < 200 && maint_oe_o !== lvl; k++) tick(1);
        while (maint_oe_o === lvl && n < 200) begin
            tick(1);
            n++;
        end
        check("drive half", PH, n);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        int unsigned c;
        logic ok;
        c = $urandom(18308);
        for (int i = 0; i < 6; i++) begin
            boot_req_i = i[0];
            boot_to_appless_i = i[1];
            ram_present_i = (i != 4);
            ram_test_en_i = i[2] ^ i[0];
            nz_bytes_i = (i == 1) ? 9'h0 : (i == 3) ? 9'h1ff : 9'($urandom_range(511));
            ram_bytes_i = 16'($urandom_range(15));
            app_ram_bytes_i = 16'($urandom_range(15));
            buffers_i = 8'($urandom_range(3));
            cksum_bytes_i = 16'($urandom_range(15));
            node_unique_id_i = 48'({$urandom(), $urandom()});
            prog_id_i = {$urandom(), $urandom()};
            press = (i == 5);
            run_init();
        end
        tick(100);
        check("pushes", 64'h1, pushes);
        check("id_prog_o", prog_id_i, id_prog_o);
        check("id_uid_o", 64'(node_unique_id_i), 64'(id_uid_o));
        check("id_prio_o", 64'h1, id_prio_o);
        tick(100);
        check("pushes", 64'h1, pushes);
        press = 1'h0;
        prio_buf_free_i = 1'h0;
        nonprio_buf_free_i = 1'h0;
        tick(40);
        press = 1'h1;
        tick(100);
        check("pushes", 64'h1, pushes);
        nonprio_buf_free_i = 1'h1;
        tick(3);
        check("pushes", 64'h2, pushes);
        check("id_prio_o", 64'h0, id_prio_o);
        press = 1'h0;
        for (int j = 0; j < 4; j++) begin
            state_code_i = (j == 0) ? 4'h4 : (j == 1) ? 4'h6 : (j == 2) ? 4'h2 : 4'h3;
            tick(2);
            c = 0;
            repeat (160) begin
                tick(1);
                c += (maint_oe_o === 1'h1);
            end
            ok = (j < 2) ? (c == 0) : (j == 2) ? (c > 0 && c < 64) : (c == 80);
            check("led drive", 64'h1, 64'(ok));
        end
        for (int k = 0; k < 100 && maint_oe_o !== 1'h0; k++) tick(1);
        span(1'h1);
        span(1'h0);
        tick(PH + 4);
        check("maint_pullup_o", 64'h1, maint_pullup_o);
        // a frozen divider must hold the input half past where it would end
        ce_i = 1'h0;
        tick(3 * PH);
        check("frozen maint_pullup_o", 64'h1, maint_pullup_o);
        check("frozen maint_oe_o", 64'h0, maint_oe_o);
        check("frozen phase_o", 64'h5, phase_o);
        ce_i = 1'h1;
        tick(2);
        pullup_dis_i = 1'h1;
        ext_pu = 1'h1;
        tick(4 * PH);
        check("maint_pullup_o", 64'h0, maint_pullup_o);
        // own low drive in the led halves must never count as a press
        check("pushes", 64'h2, pushes);
        end_of_test();
    end
endmodule

bind reset_init_and_maint_pin_control reset_init_props u_reset_init_props (.clk_sys_i,
    .rstn_i, .boot_req_i, .pullup_dis_i, .prio_buf_free_i, .nonprio_buf_free_i,
    .node_unique_id_i, .maint_pin_o, .maint_oe_o, .maint_pullup_o, .phase_o, .init_done_o,
    .par_init_run_o, .id_push_o, .id_prio_o, .id_uid_o);
